//--- bcs_pkg.sv
/*
 Shared constants for the angle sensor serial slave: frame layout, check code,
 link timing and measurement timing. Assumes a 50 MHz system clock.
*/
package bcs_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int POS_BITS = 22;
    localparam int POS_RES = 22;
    localparam int DATA_BITS = 24;
    localparam int CRC_BITS = 6;
    localparam int SCD_BITS = 30;
    localparam int PROC_PERIODS = 12;
    localparam logic [5:0] CRC_POLY = 6'h03;
    localparam logic [5:0] CRC_INIT = 6'h00;
    localparam logic SLI_LEVEL = 1'b0;
    localparam int ERR_POS = 1;
    localparam int WARN_POS = 0;
    localparam logic [23:0] RESULT_RST = 24'h000001;
    localparam int LINK_TMO_NS = 15000;
    localparam int MEAS_TIME_NS = 90000;
    localparam int AUTO_TRIG_NS = 135000;
    localparam int LINK_TMO_CYCLES = (LINK_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEAS_CYCLES = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTO_TRIG_CYCLES = (AUTO_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
endpackage

//--- bcs_stream_if.sv
/*
 Valid/ready stream carrying one 24-bit data area between blocks.
 Assumes both ends on the system clock.
*/
`timescale 1ns/1ns
interface bcs_stream_if;
    logic valid;
    logic ready;
    logic [23:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- bcs_buf2.sv
/*
 Two-entry buffer between measurement capture and the frame shifter.
 Assumes synchronous active-high reset on the system clock.
*/
`timescale 1ns/1ns
module bcs_buf2
    import bcs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    bcs_stream_if.snk s_in,
    bcs_stream_if.src s_out
);
    logic [23:0] mem_q [2];
    logic [23:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = s_in.valid && (cnt_q != 2'h2);
        pop = s_out.ready && (cnt_q != 2'h0);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = s_in.data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mem_q[0] <= 24'h000000;
            mem_q[1] <= 24'h000000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign s_in.ready = (cnt_q != 2'h2);
    assign s_out.valid = (cnt_q != 2'h0);
    assign s_out.data = mem_q[rd_q];
endmodule

//--- bcs_slave.sv
/*
 Serial slave of the angle sensor: samples the master clock, runs the
 measurement timing and shifts out the 30-bit single-cycle data word.
 Assumes the sensor core on the system clock presents position and validity
 continuously; the master clock pin is asynchronous.
*/
`timescale 1ns/1ns
module bcs_slave
    import bcs_pkg::*;
#(
    parameter int MEAS_CYC = MEAS_CYCLES,
    parameter int AUTO_CYC = AUTO_TRIG_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ma,
    input wire logic [21:0] i_sensor_pos,
    input wire logic i_sensor_ok,
    output logic o_sl,
    output logic o_meas_trigger,
    output logic o_link_busy
);
    typedef enum {ST_IDLE, ST_ACK, ST_CDS, ST_DATA, ST_TMO} bcs_state_type;

    function automatic logic [5:0] bcs_crc6(input logic [23:0] d);
        logic [5:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = DATA_BITS - 1; i >= 0; i--) begin
            fb = d[i] ^ c[5];
            c = {c[4:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    localparam logic [CNT_W-1:0] MEAS_LAST = CNT_W'(MEAS_CYC - 1);
    localparam logic [CNT_W-1:0] AUTO_LAST = CNT_W'(AUTO_CYC - 1);
    localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(LINK_TMO_CYCLES - 1);
    localparam logic [4:0] PROC_LAST = 5'(PROC_PERIODS);
    localparam logic [4:0] SCD_LAST = 5'(SCD_BITS - 1);
    localparam logic [21:0] RES_MASK = ~22'(({POS_BITS{1'b1}} >> POS_RES));

    bcs_stream_if meas_s ();
    bcs_stream_if held_s ();

    bcs_buf2 u_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .s_in(meas_s.snk),
        .s_out(held_s.src)
    );

    // Master clock sync; the second and third stages feed edge detection
    logic ma_s1_q, ma_s2_q, ma_s3_q;
    logic ma_rise, ma_fall;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ma_s1_q <= 1'b1;
            ma_s2_q <= 1'b1;
            ma_s3_q <= 1'b1;
        end else begin
            ma_s1_q <= i_ma;
            ma_s2_q <= ma_s1_q;
            ma_s3_q <= ma_s2_q;
        end
    end

    assign ma_rise = ma_s2_q && !ma_s3_q;
    assign ma_fall = !ma_s2_q && ma_s3_q;

    // Frame sequencer
    bcs_state_type st_q, st_d;
    logic sl_q, sl_d;
    logic busy_q, busy_d;
    logic [4:0] bit_q, bit_d;
    logic [29:0] sh_q, sh_d;
    logic [CNT_W-1:0] tmo_q, tmo_d;
    logic [23:0] latest_q, latest_d;
    logic frame_start;

    assign held_s.ready = (st_q == ST_IDLE);

    always_comb begin
        st_d = st_q;
        sl_d = sl_q;
        bit_d = bit_q;
        sh_d = sh_q;
        latest_d = latest_q;
        frame_start = 1'b0;
        tmo_d = (ma_rise || ma_fall) ? '0 : tmo_q + CNT_W'(1);
        if (held_s.valid && held_s.ready) begin
            latest_d = held_s.data;
        end
        case (st_q)
            ST_IDLE: begin
                sl_d = 1'b1;
                tmo_d = '0;
                if (ma_fall) begin
                    frame_start = 1'b1;
                    // Word carries the result that was latest before this frame
                    sh_d = {latest_q, ~bcs_crc6(latest_q)};
                    bit_d = 5'h00;
                    st_d = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ma_rise) begin
                    if (bit_q == PROC_LAST) begin
                        sl_d = 1'b1;
                        st_d = ST_CDS;
                    end else begin
                        sl_d = 1'b0;
                        bit_d = bit_q + 5'h01;
                    end
                end
            end
            ST_CDS: begin
                if (ma_rise) begin
                    sl_d = 1'b0;
                    bit_d = 5'h00;
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (ma_rise) begin
                    sl_d = sh_q[29];
                    sh_d = {sh_q[28:0], SLI_LEVEL};
                    bit_d = bit_q + 5'h01;
                    if (bit_q == SCD_LAST) begin
                        st_d = ST_TMO;
                    end
                end
            end
            ST_TMO: begin
                if (ma_rise) begin
                    sl_d = 1'b0;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // A quiet clock line ends the frame and also recovers a broken one
        if (st_q != ST_IDLE && tmo_q == TMO_LAST) begin
            st_d = ST_IDLE;
            sl_d = 1'b1;
        end
        busy_d = (st_d != ST_IDLE);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            sl_q <= 1'b1;
            busy_q <= 1'b0;
            bit_q <= 5'h00;
            sh_q <= 30'h00000000;
            tmo_q <= '0;
            latest_q <= RESULT_RST;
        end else begin
            st_q <= st_d;
            sl_q <= sl_d;
            busy_q <= busy_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tmo_q <= tmo_d;
            latest_q <= latest_d;
        end
    end

    // Measurement timing
    logic mbusy_q, mbusy_d;
    logic trig_q, trig_d;
    logic [CNT_W-1:0] mcnt_q, mcnt_d;
    logic [CNT_W-1:0] since_q, since_d;
    logic pend_q, pend_d;
    logic [23:0] res_q, res_d;

    assign meas_s.valid = pend_q;
    assign meas_s.data = res_q;

    always_comb begin
        mbusy_d = mbusy_q;
        mcnt_d = mcnt_q;
        pend_d = pend_q && !meas_s.ready;
        res_d = res_q;
        trig_d = 1'b0;
        since_d = (since_q == AUTO_LAST) ? since_q : since_q + CNT_W'(1);
        if (mbusy_q) begin
            if (mcnt_q != MEAS_LAST) begin
                mcnt_d = mcnt_q + CNT_W'(1);
            end else if (!pend_d) begin
                // Capture waits while the previous result is still pending on a full buffer, so no result is dropped
                mbusy_d = 1'b0;
                pend_d = 1'b1;
                res_d = {i_sensor_pos & RES_MASK, i_sensor_ok, 1'b1};
            end
        end else if (frame_start || since_q == AUTO_LAST) begin
            mbusy_d = 1'b1;
            mcnt_d = '0;
            since_d = '0;
            trig_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mbusy_q <= 1'b0;
            trig_q <= 1'b0;
            mcnt_q <= '0;
            since_q <= '0;
            pend_q <= 1'b0;
            res_q <= RESULT_RST;
        end else begin
            mbusy_q <= mbusy_d;
            trig_q <= trig_d;
            mcnt_q <= mcnt_d;
            since_q <= since_d;
            pend_q <= pend_d;
            res_q <= res_d;
        end
    end

    assign o_sl = sl_q;
    assign o_meas_trigger = trig_q;
    assign o_link_busy = busy_q;
endmodule

//--- bcs_slave_props.sv
/* Checker for the serial slave top-level ports.
 Assumes MA changes away from the system clock edge. */
`timescale 1ns/1ns
module bcs_slave_props #(
    parameter int MEAS_CYC = 20,
    parameter int AUTO_CYC = 40
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ma,
    input wire logic [21:0] i_sensor_pos,
    input wire logic i_sensor_ok,
    input wire logic o_sl,
    input wire logic o_meas_trigger,
    input wire logic o_link_busy
);
    logic ma_q;
    logic [15:0] ma_cnt_q, ma_cnt_d, trg_cnt_q, trg_cnt_d;
    // Counters saturate so a long idle never wraps into a false window
    always_comb begin
        ma_cnt_d = (&ma_cnt_q) ? ma_cnt_q : ma_cnt_q + 16'h0001;
        trg_cnt_d = (&trg_cnt_q) ? trg_cnt_q : trg_cnt_q + 16'h0001;
        if (i_ma != ma_q) ma_cnt_d = 16'h0000;
        if (o_meas_trigger) trg_cnt_d = 16'h0000;
    end
    always_ff @(posedge i_sys_clk) begin
        ma_q <= i_ma;
        ma_cnt_q <= i_rst ? 16'h0000 : ma_cnt_d;
        trg_cnt_q <= i_rst ? 16'h0000 : trg_cnt_d;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence frame_start;
        $fell(i_ma) && !o_link_busy;
    endsequence
    sequence ack_low;
        (!o_sl) [*8];
    endsequence
    frame_busy_a: assert property (frame_start |-> ##[2:6] o_link_busy)
        else $error("frame start not taken");
    ack_start_a: assert property (frame_start |-> ##12 ack_low ##[84:88] o_sl)
        else $error("ack phase or start bit wrong");
    idle_line_a: assert property ((!o_link_busy) [*3] |-> o_sl)
        else $error("data line low while idle");
    sl_after_rise_a: assert property ($changed(o_sl) && o_link_busy && ma_cnt_q < 16'd700
        |-> $past(i_ma, 3) && !$past(i_ma, 6))
        else $error("data line changed away from MA rise");
    timeout_len_a: assert property ($fell(o_link_busy) |-> ma_cnt_q inside {[750:770]})
        else $error("link timeout length wrong");
    busy_hold_a: assert property (o_link_busy && ma_cnt_q < 16'd740 |=> o_link_busy)
        else $error("link left busy too early");
    ready_again_a: assert property (ma_cnt_q > 16'd780 |-> !o_link_busy && o_sl)
        else $error("link not ready after timeout");
    trig_gap_a: assert property (o_meas_trigger |-> trg_cnt_q >= MEAS_CYC - 2)
        else $error("trigger while measurement running");
    auto_trig_a: assert property (trg_cnt_q <= AUTO_CYC + 4)
        else $error("no automatic measurement");
endmodule
bind bcs_slave bcs_slave_props #(.MEAS_CYC(MEAS_CYC), .AUTO_CYC(AUTO_CYC)) u_props (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ma(i_ma), .i_sensor_pos(i_sensor_pos),
    .i_sensor_ok(i_sensor_ok), .o_sl(o_sl), .o_meas_trigger(o_meas_trigger),
    .o_link_busy(o_link_busy));

//--- bcs_master_model.sv
/* Master side of the link: clocks whole frames on MA and samples SL.
 Assumes the slave answers within one MA period of a rising edge. */
`timescale 1ns/1ns
module bcs_master_model #(
    // Bench runs MA faster than a field master would, to keep runs short
    parameter int HALF_NS = 80
) (
    output logic o_ma,
    input wire logic i_sl
);
    initial o_ma = 1'h1;
    // One fall, then 45 rises; SL is read just before each next rise
    task automatic frame(output logic [44:0] bits);
        o_ma = 1'h0;
        #(HALF_NS);
        for (int r = 44; r >= 0; r--) begin
            o_ma = 1'h1;
            #(HALF_NS);
            if (r > 0) o_ma = 1'h0;
            #(HALF_NS - 20);
            bits[r] = i_sl;
            #20;
        end
    endtask
    task automatic glitch();
        o_ma = 1'h0;
        #(HALF_NS);
        o_ma = 1'h1;
    endtask
endmodule

//--- tb_top.sv
/* Bench for the serial slave: a table of positions framed by the master model.
 Assumes short measurement counts and frames spaced beyond the link timeout. */
`timescale 1ns/1ns
module tb_top;
    localparam int MEAS_T = 20;
    localparam int AUTO_T = 2000;
    logic clk, rst, ma, sl, trig, busy, ok;
    logic [21:0] pos;
    logic [44:0] bits;
    logic [23:0] prev;
    int fails = 0, n_checks = 0, n_trig = 0, k, t;
    logic [22:0] rows [5] = '{{22'h3fffff, 1'h1}, {22'h000000, 1'h1}, {22'h2aaaaa, 1'h0},
        {22'h155555, 1'h1}, {22'h000001, 1'h1}};
    bcs_slave #(.MEAS_CYC(MEAS_T), .AUTO_CYC(AUTO_T)) dut (.i_sys_clk(clk), .i_rst(rst),
        .i_ma(ma), .i_sensor_pos(pos), .i_sensor_ok(ok), .o_sl(sl), .o_meas_trigger(trig),
        .o_link_busy(busy));
    bcs_master_model u_master (.o_ma(ma), .i_sl(sl));
    always @(posedge clk) if (trig === 1'h1) n_trig <= n_trig + 1;
    function automatic logic [44:0] frame_exp(input logic [23:0] d);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 23; i >= 0; i--) c = {c[4:0], 1'h0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
        return {12'h000, 2'h2, d, ~c, 1'h0};
    endfunction
    task automatic results();
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [44:0] got, input logic [44:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: frame %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic c);
        n_checks++;
        if (c !== 1'h1) begin
            fails++;
            $display("Error %0t: port state wrong", $time);
        end
    endtask
    // Link must see 15 us of quiet before the next frame is taken
    task automatic do_frame(input logic [23:0] d);
        u_master.frame(bits);
        chk(bits, frame_exp(d));
        repeat (800) @(posedge clk);
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'h1;
        pos = 22'h000000;
        ok = 1'h0;
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        repeat (30) @(negedge clk);
        prev = 24'h000001;
        foreach (rows[i]) begin
            @(negedge clk);
            pos = rows[i][22:1];
            ok = rows[i][0];
            do_frame(prev);
            prev = {rows[i], 1'h1};
        end
        k = 0;
        while (trig !== 1'h1 && k < 2100) begin
            @(negedge clk);
            k++;
        end
        if (k == 2100) begin
            fails++;
            results();
        end
        chk1(k >= 825 && k <= 855);
        @(negedge clk) pos = 22'h0f0f0f;
        t = n_trig;
        do_frame(prev);
        chk1(n_trig == t);
        @(negedge clk);
        u_master.frame(bits);
        chk(bits, frame_exp({22'h0f0f0f, 2'h3}));
        repeat (400) @(negedge clk);
        u_master.glitch();
        repeat (400) @(negedge clk);
        chk1({busy, sl} === 2'h2);
        repeat (400) @(negedge clk);
        chk1({busy, sl} === 2'h1);
        rst = 1'h1;
        repeat (3) @(negedge clk);
        chk1({busy, sl, trig} === 3'h2);
        rst = 1'h0;
        repeat (30) @(negedge clk);
        do_frame(24'h000001);
        results();
    end
endmodule
